/* File: rld_map.vh */
`ifndef RLD_MAP_VH
`define RLD_MAP_VH
// register word indices; the byte address is four times the index
`define RLD_IDX_OPCTL2    8'h08
`define RLD_IDX_PAD0      8'h0b
`define RLD_IDX_PAD1      8'h0c
`define RLD_IDX_PAD2      8'h0d
`define RLD_IDX_IOPORT    8'h0e
`define RLD_IDX_WUTPER1   8'h14
`define RLD_IDX_WUTPER2   8'h15
`define RLD_IDX_WUTPER3   8'h16
`define RLD_IDX_LDCDUR    8'h19
`define RLD_IDX_RSSI      8'h26
`define RLD_IDX_RSSITH    8'h27
`define RLD_IDX_STATUS2   8'h04
// field positions
`define RLD_ANT_MSB       7
`define RLD_ANT_LSB       5
`define RLD_LDC_EN_BIT    2
`define RLD_DRV_MSB       7
`define RLD_DRV_LSB       6
`define RLD_PUP_BIT       5
`define RLD_FUN_MSB       4
`define RLD_RSSI_ST_BIT   4
// reset values
`define RLD_RST_BYTE      8'h00
`define RLD_RST_WUTPER1   8'h03
`define RLD_RST_WUTPER3   8'h01
// timing: 32.768 kHz tick = 30517.578 ns -> 3052 cycles at 100 MHz
`define RLD_SYS_CLK_MHZ   100
`define RLD_LF_PERIOD_PS  30517578
`define RLD_LF_CYCLES     ((`RLD_LF_PERIOD_PS + `RLD_SYS_CLK_MHZ * 10 - 1) / (1000000 / `RLD_SYS_CLK_MHZ) / 1)
`define RLD_LF_DIV        12'd3052
`define RLD_ANT_DWELL     16'd400
`endif

/* File: rld_radio_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rld_radio_model (
  // clock
  input  wire logic       sys_clk,
  // bench commands
  input  wire logic       sigOn,
  input  wire logic       shutOn,
  input  wire logic       porOn,
  input  wire logic       rxForce,
  // device side
  input  wire logic       rxEnable,
  input  wire logic [1:0] antSel,
  output logic            shutdownIn,
  output logic            rxActiveIn,
  output logic            preambleValidIn,
  output logic            syncValidIn,
  output logic            porIn,
  output logic            mcuClkIn,
  output logic            bitTickIn,
  output logic [7:0]      rssiIn
);
  // =====
  // radio core and antenna switch
  logic [2:0]  divCnt = 3'h0;
  logic [10:0] airCnt = 11'h0;
  initial {shutdownIn, rxActiveIn, preambleValidIn, syncValidIn, porIn, mcuClkIn, bitTickIn, rssiIn} = 15'h0;
  always @(posedge sys_clk) begin
    divCnt <= divCnt + 3'h1;
    bitTickIn <= divCnt[2];
    mcuClkIn <= divCnt[1];
    shutdownIn <= shutOn;
    porIn <= porOn;
    rxActiveIn <= rxForce | rxEnable;
    airCnt <= (sigOn && rxActiveIn) ? airCnt + {10'h0, airCnt != 11'h7ff} : 11'h0;
    // long preamble so that both antennas are heard before it is valid
    preambleValidIn <= airCnt > 11'd900;
    syncValidIn <= airCnt > 11'd1000;
    // antenna one hears the stronger copy; noise floor when silent
    rssiIn <= !sigOn ? 8'h08 : antSel[0] ? 8'h60 : 8'h30;
  end
endmodule
`default_nettype wire

/* File: rld_rx_aux.v */
// Behaviour
// RQ1: no preamble or sync: sleep till period
// RQ2: preamble and sync: hold receiver full window
// RQ3: one exponent scales period and window
// RQ4: window = count*4*2^R ticks of 32.768k
// RQ5: period = 4*mantissa*2^R ticks, window starts
// RQ6: listening runs only while enable bit set
// RQ7: shutdown pulls all three pads low
// RQ8: code zero per pad: reset, inverted, clock
// RQ9: per pad drive, pull-up, five-bit function
// RQ10: host avoids ADC pad input when idle
// RQ11: diversity picks stronger antenna during preamble
// RQ12: diversity toggles antennas until packet arrives
// RQ13: fixed antenna codes zero to three
// RQ14: algorithm codes; idle outputs follow parity
// RQ15: sender uses eight or four byte preamble
// RQ16: eight-bit signal strength readable any time
// RQ17: strength refreshed every four bit periods
// RQ18: host reads strength safely by method
// RQ19: strength above threshold sets status bit; the code compares only when preamble valid rises
// RQ20: pad function 1110 shows clear-channel status
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "rld_map.vh"
module rld_rx_aux (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // radio core status (asynchronous to this block)
  input  wire        shutdownIn,
  input  wire        rxActiveIn,
  input  wire        preambleValidIn,
  input  wire        syncValidIn,
  input  wire        porIn,
  input  wire        mcuClkIn,
  input  wire [7:0]  rssiIn,
  input  wire        bitTickIn,
  // receiver control
  output reg         rxEnable,
  // pads
  output reg  [2:0]  padOut,
  output reg  [2:0]  padOe,
  output reg  [2:0]  padPullup,
  output reg  [5:0]  padDrive
);

// ==========================================================
// input synchronisers
localparam NSYNC = 6;
wire [NSYNC-1:0] rawIn = {shutdownIn, rxActiveIn, preambleValidIn, syncValidIn, porIn, bitTickIn};
reg  [NSYNC-1:0] sync1_reg;
reg  [NSYNC-1:0] sync2_reg;
reg  [7:0]       rssiS1_reg;
reg  [7:0]       rssiS2_reg;
reg              mcuS1_reg;
reg              mcuS2_reg;
always @(posedge sys_clk or posedge rst) begin
  if (rst) begin
    sync1_reg  <= 6'h00;
    sync2_reg  <= 6'h00;
    rssiS1_reg <= 8'h00;
    rssiS2_reg <= 8'h00;
    mcuS1_reg  <= 1'b0;
    mcuS2_reg  <= 1'b0;
  end else begin
    sync1_reg  <= rawIn;
    sync2_reg  <= sync1_reg;
    rssiS1_reg <= rssiIn;
    rssiS2_reg <= rssiS1_reg;
    mcuS1_reg  <= mcuClkIn;
    mcuS2_reg  <= mcuS1_reg;
  end
end
wire shutdownS = sync2_reg[5];
wire rxActS    = sync2_reg[4];
wire preS      = sync2_reg[3];
wire syncS     = sync2_reg[2];
wire porS      = sync2_reg[1];
wire bitTickS  = sync2_reg[0];

// ==========================================================
// register file
reg  [7:0] opctl2_reg;
reg  [7:0] pad0_reg;
reg  [7:0] pad1_reg;
reg  [7:0] pad2_reg;
reg  [7:0] ioport_reg;
reg  [7:0] wut1_reg;
reg  [7:0] wut2_reg;
reg  [7:0] wut3_reg;
reg  [7:0] ldc_reg;
reg  [7:0] rssith_reg;
reg  [7:0] rssiVal_reg;
reg        rssiStat_reg;
reg        wrPend_reg;
reg  [7:0] wrIdx_reg;
reg        rdPend_reg;
reg  [7:0] rdIdx_reg;
reg        statClr;

wire       busTake = hsel & hready & htrans[1];
wire [7:0] busIdx  = haddr[9:2];

function [7:0] rdMux;
  input [7:0] idx;
  begin
    case (idx)
      `RLD_IDX_OPCTL2:  rdMux = opctl2_reg;
      `RLD_IDX_PAD0:    rdMux = pad0_reg;
      `RLD_IDX_PAD1:    rdMux = pad1_reg;
      `RLD_IDX_PAD2:    rdMux = pad2_reg;
      `RLD_IDX_IOPORT:  rdMux = ioport_reg;
      `RLD_IDX_WUTPER1: rdMux = wut1_reg;
      `RLD_IDX_WUTPER2: rdMux = wut2_reg;
      `RLD_IDX_WUTPER3: rdMux = wut3_reg;
      `RLD_IDX_LDCDUR:  rdMux = ldc_reg;
      `RLD_IDX_RSSI:    rdMux = rssiVal_reg; // RQ16
      `RLD_IDX_RSSITH:  rdMux = rssith_reg;
      `RLD_IDX_STATUS2: rdMux = {3'h0, rssiStat_reg, 4'h0};
      default:          rdMux = 8'h00;
    endcase
  end
endfunction

always @(posedge sys_clk or posedge rst) begin
  if (rst) begin
    wrPend_reg <= 1'b0;
    wrIdx_reg  <= 8'h00;
    rdPend_reg <= 1'b0;
    rdIdx_reg  <= 8'h00;
    hrdata     <= 32'h00000000;
    hreadyout  <= 1'b1;
    hresp      <= 1'b0;
    opctl2_reg <= `RLD_RST_BYTE;
    pad0_reg   <= `RLD_RST_BYTE;
    pad1_reg   <= `RLD_RST_BYTE;
    pad2_reg   <= `RLD_RST_BYTE;
    ioport_reg <= `RLD_RST_BYTE;
    wut1_reg   <= `RLD_RST_WUTPER1;
    wut2_reg   <= `RLD_RST_BYTE;
    wut3_reg   <= `RLD_RST_WUTPER3;
    ldc_reg    <= `RLD_RST_BYTE;
    rssith_reg <= `RLD_RST_BYTE;
  end else begin
    wrPend_reg <= busTake & hwrite;
    wrIdx_reg  <= busIdx;
    rdPend_reg <= busTake & ~hwrite;
    rdIdx_reg  <= busIdx;
    hreadyout  <= 1'b1;
    hresp      <= 1'b0;
    // read data registered at the address phase so hrdata stands in the data phase
    if (busTake & ~hwrite) begin
      hrdata <= {24'h000000, rdMux(busIdx)};
    end
    if (wrPend_reg) begin
      case (wrIdx_reg)
        `RLD_IDX_OPCTL2:  opctl2_reg <= hwdata[7:0];
        `RLD_IDX_PAD0:    pad0_reg   <= hwdata[7:0]; // RQ9
        `RLD_IDX_PAD1:    pad1_reg   <= hwdata[7:0];
        `RLD_IDX_PAD2:    pad2_reg   <= hwdata[7:0];
        `RLD_IDX_IOPORT:  ioport_reg <= hwdata[7:0];
        `RLD_IDX_WUTPER1: wut1_reg   <= hwdata[7:0];
        `RLD_IDX_WUTPER2: wut2_reg   <= hwdata[7:0];
        `RLD_IDX_WUTPER3: wut3_reg   <= hwdata[7:0];
        `RLD_IDX_LDCDUR:  ldc_reg    <= hwdata[7:0];
        `RLD_IDX_RSSITH:  rssith_reg <= hwdata[7:0];
        default: begin
        end
      endcase
    end
  end
end

// status bit clears on read of its register
always @* begin
  statClr = rdPend_reg & (rdIdx_reg == `RLD_IDX_STATUS2);
end

// ==========================================================
// 32.768 kHz tick from divider
reg [11:0] lfDiv_reg;
reg        lfTick_reg;
always @(posedge sys_clk or posedge rst) begin
  if (rst) begin
    lfDiv_reg  <= 12'h000;
    lfTick_reg <= 1'b0;
  end else begin
    lfTick_reg <= (lfDiv_reg == `RLD_LF_DIV - 12'd1);
    if (lfDiv_reg == `RLD_LF_DIV - 12'd1) begin
      lfDiv_reg <= 12'h000;
    end else begin
      lfDiv_reg <= lfDiv_reg + 12'd1;
    end
  end
end

// ==========================================================
// low duty cycle listening
localparam LS_IDLE  = 2'd0;
localparam LS_SLEEP = 2'd1;
localparam LS_LOOK  = 2'd2;
localparam LS_HOLD  = 2'd3;
reg  [1:0]  lState_reg;
reg  [39:0] perCnt_reg;
reg  [39:0] winCnt_reg;
wire [4:0]  expR     = wut1_reg[4:0];                              // RQ3
wire [39:0] perTicks = ({22'h0, wut2_reg, wut3_reg, 2'b00}) << expR; // RQ5
wire [39:0] winTicks = ({30'h0, ldc_reg, 2'b00}) << expR;          // RQ4
wire        ldcEn    = opctl2_reg[`RLD_LDC_EN_BIT];
wire        perEnd   = lfTick_reg & (perCnt_reg + 40'd1 >= perTicks);
always @(posedge sys_clk or posedge rst) begin
  if (rst) begin
    lState_reg <= LS_IDLE;
    perCnt_reg <= 40'h0;
    winCnt_reg <= 40'h0;
    rxEnable   <= 1'b0;
  end else if (!ldcEn) begin // RQ6
    lState_reg <= LS_IDLE;
    perCnt_reg <= 40'h0;
    winCnt_reg <= 40'h0;
    rxEnable   <= 1'b0;
  end else begin
    if (perEnd) begin
      perCnt_reg <= 40'h0;
    end else if (lfTick_reg) begin
      perCnt_reg <= perCnt_reg + 40'd1;
    end
    case (lState_reg)
      LS_IDLE: begin
        lState_reg <= LS_SLEEP;
      end
      LS_SLEEP: begin
        if (perEnd) begin // RQ5
          lState_reg <= LS_LOOK;
          winCnt_reg <= 40'h0;
          rxEnable   <= 1'b1;
        end
      end
      LS_LOOK: begin
        if (lfTick_reg) begin
          winCnt_reg <= winCnt_reg + 40'd1;
        end
        if (preS & syncS) begin // RQ2
          lState_reg <= LS_HOLD;
          winCnt_reg <= 40'h0;
        end else if (lfTick_reg & (winCnt_reg + 40'd1 >= winTicks)) begin // RQ1
          lState_reg <= LS_SLEEP;
          rxEnable   <= 1'b0;
        end
      end
      LS_HOLD: begin
        if (lfTick_reg) begin
          winCnt_reg <= winCnt_reg + 40'd1;
        end
        // full window counted from the first tick after sync; the partial tick before it is extra
        if (lfTick_reg & (winCnt_reg >= winTicks)) begin // RQ2
          lState_reg <= LS_SLEEP;
          rxEnable   <= 1'b0;
        end
      end
      default: begin
        lState_reg <= LS_IDLE;
      end
    endcase
  end
end

// ==========================================================
// signal strength sampling and clear-channel decision
reg [1:0] bitCnt_reg;
reg       bitTickD_reg;
reg       preD_reg;
wire      bitEdge = bitTickS & ~bitTickD_reg;
wire      ccaEval = preS & ~preD_reg;
always @(posedge sys_clk or posedge rst) begin
  if (rst) begin
    bitCnt_reg   <= 2'd0;
    bitTickD_reg <= 1'b0;
    preD_reg     <= 1'b0;
    rssiVal_reg  <= 8'h00;
    rssiStat_reg <= 1'b0;
  end else begin
    bitTickD_reg <= bitTickS;
    preD_reg     <= preS;
    if (bitEdge) begin
      bitCnt_reg <= bitCnt_reg + 2'd1;
      if (bitCnt_reg == 2'd3) begin
        rssiVal_reg <= rssiS2_reg; // RQ17
      end
    end
    // set wins over the read clear
    if (ccaEval & (rssiVal_reg > rssith_reg)) begin // RQ19
      rssiStat_reg <= 1'b1;
    end else if (statClr) begin
      rssiStat_reg <= 1'b0;
    end
  end
end

// clear-channel level for pads tracks live comparison while receiving
reg ccaLevel_reg;
always @(posedge sys_clk or posedge rst) begin
  if (rst) begin
    ccaLevel_reg <= 1'b0;
  end else begin
    ccaLevel_reg <= rxActS & (rssiVal_reg > rssith_reg);
  end
end

// ==========================================================
// antenna diversity
wire [2:0]  antMode = opctl2_reg[`RLD_ANT_MSB:`RLD_ANT_LSB];
reg  [15:0] dwell_reg;
reg         antSel_reg;
reg         antLock_reg;
reg  [7:0]  rssiA_reg;
reg         rxActD_reg;
reg         ant1_reg;
reg         ant2_reg;
always @(posedge sys_clk or posedge rst) begin
  if (rst) begin
    dwell_reg   <= 16'h0000;
    antSel_reg  <= 1'b0;
    antLock_reg <= 1'b0;
    rssiA_reg   <= 8'h00;
    rxActD_reg  <= 1'b0;
  end else begin
    rxActD_reg <= rxActS;
    if (!rxActS | (rxActS & ~rxActD_reg)) begin
      antLock_reg <= 1'b0;
      dwell_reg   <= 16'h0000;
      // beacon variant starts on antenna 0 at receive entry, packets are synchronous
      antSel_reg  <= 1'b0;
    end else if (!antLock_reg) begin
      if (preS) begin // RQ11
        antLock_reg <= 1'b1;
        antSel_reg  <= (rssiS2_reg >= rssiA_reg) ? antSel_reg : ~antSel_reg;
      end else if (dwell_reg == `RLD_ANT_DWELL) begin // RQ12
        dwell_reg  <= 16'h0000;
        antSel_reg <= ~antSel_reg;
        rssiA_reg  <= rssiS2_reg;
      end else begin
        dwell_reg <= dwell_reg + 16'd1;
      end
    end
  end
end

always @(posedge sys_clk or posedge rst) begin
  if (rst) begin
    ant1_reg <= 1'b0;
    ant2_reg <= 1'b0;
  end else if (!rxActS) begin
    ant1_reg <= antMode[2] ? antMode[0] : antMode[1]; // RQ14
    ant2_reg <= antMode[2] ? antMode[0] : antMode[1]; // RQ13
  end else if (antMode[2]) begin
    ant1_reg <= antSel_reg;
    ant2_reg <= ~antSel_reg;
  end else begin
    ant1_reg <= antMode[0]; // RQ13
    ant2_reg <= ~antMode[0];
  end
end

// ==========================================================
// pad function mux; codes beyond these drive low
function padFn;
  input [4:0] fn;
  input [1:0] pad;
  input       por;
  input       mclk;
  input       a1;
  input       a2;
  input       cca;
  input       rxOn;
  begin
    case (fn)
      5'h00:   padFn = (pad == 2'd0) ? por : (pad == 2'd1) ? ~por : mclk; // RQ8
      5'h03:   padFn = a1;
      5'h04:   padFn = a2;
      5'h0e:   padFn = cca; // RQ20
      5'h12:   padFn = rxOn;
      5'h1e:   padFn = cca;
      default: padFn = 1'b0;
    endcase
  end
endfunction

wire [23:0] padCfg = {pad2_reg, pad1_reg, pad0_reg};
genvar gp;
generate
  for (gp = 0; gp < 3; gp = gp + 1) begin : gPad
    localparam integer PAD_IDX = gp;
    wire [7:0] cfg = padCfg[gp*8 +: 8];
    always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        padOut[gp]         <= 1'b0;
        padOe[gp]          <= 1'b0;
        padPullup[gp]      <= 1'b0;
        padDrive[gp*2 +: 2] <= 2'b00;
      end else if (shutdownS) begin // RQ7
        padOut[gp]         <= 1'b0;
        padOe[gp]          <= 1'b1;
        padPullup[gp]      <= 1'b0;
        padDrive[gp*2 +: 2] <= cfg[`RLD_DRV_MSB:`RLD_DRV_LSB];
      end else begin
        padOut[gp]         <= padFn(cfg[`RLD_FUN_MSB:0], PAD_IDX[1:0], porS, mcuS2_reg,
                                    ant1_reg, ant2_reg, ccaLevel_reg, rxEnable);
        padOe[gp]          <= 1'b1;
        padPullup[gp]      <= cfg[`RLD_PUP_BIT]; // RQ9
        padDrive[gp*2 +: 2] <= cfg[`RLD_DRV_MSB:`RLD_DRV_LSB];
      end
    end
  end
endgenerate

endmodule
`default_nettype wire

/* File: rld_rx_aux_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module rld_rx_aux_asserts (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // radio and pads
  input wire logic        shutdownIn,
  input wire logic        rxEnable,
  input wire logic [2:0]  padOut,
  input wire logic [2:0]  padPullup,
  input wire logic [5:0]  padDrive
);
  // =====
  // bus and pad relations
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire rdTake = hsel && hready && htrans[1] && !hwrite;
  wire wrTake = hsel && hready && htrans[1] && hwrite;
  ready_high_a: assert property (hreadyout) else $error("wait state seen");
  resp_okay_a: assert property (!hresp) else $error("error response seen");
  rdata_upper_a: assert property (rdTake |=> hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  rdata_hold_a: assert property (!rdTake |=> $stable(hrdata)) else $error("read data moved");
  // sync stages plus output flop need three edges
  shut_low_a: assert property (shutdownIn [*4] |-> padOut == 3'b000)
    else $error("pad high in shutdown");
  drive_set_a: assert property (wrTake && haddr == 32'h2c ##1 hwdata[7:6] == 2'b10 |-> ##2 padDrive[1:0] == 2'b10)
    else $error("drive not applied");
  pullup_set_a: assert property (wrTake && haddr == 32'h2c ##1 hwdata[5] |-> ##2 padPullup[0])
    else $error("pullup not applied");
  listen_off_a: assert property (wrTake && haddr == 32'h20 ##1 !hwdata[2] |-> ##[1:2] !rxEnable)
    else $error("receiver still on");
endmodule
bind rld_rx_aux rld_rx_aux_asserts u_chk (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hrdata, .hreadyout, .hresp, .shutdownIn, .rxEnable, .padOut, .padPullup, .padDrive);
`default_nettype wire

/* File: rld_rx_aux_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module rld_rx_aux_bench;
  // =====
  // signals
  logic sys_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic sigOn = 1'b0, shutOn = 1'b0, porOn = 1'b0, rxForce = 1'b0;
  logic shutdownIn, rxActiveIn, preambleValidIn, syncValidIn, porIn, mcuClkIn, bitTickIn;
  logic [7:0] rssiIn;
  wire [31:0] hrdata;
  wire hreadyout, hresp, rxEnable;
  wire [2:0] padOut, padOe, padPullup;
  wire [5:0] padDrive;
  int fails = 0, checks = 0;
  logic [7:0] rIdx [10] = '{8'h08, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h14, 8'h15, 8'h16, 8'h19, 8'h27};
  logic [7:0] rVal [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h01, 8'h00, 8'h00};
  rld_rx_aux DUT (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .shutdownIn, .rxActiveIn, .preambleValidIn,
    .syncValidIn, .porIn, .mcuClkIn, .rssiIn, .bitTickIn, .rxEnable, .padOut, .padOe, .padPullup, .padDrive);
  rld_radio_model far (.sys_clk, .sigOn, .shutOn, .porOn, .rxForce, .rxEnable, .antSel(padOut[1:0]),
    .shutdownIn, .rxActiveIn, .preambleValidIn, .syncValidIn, .porIn, .mcuClkIn, .bitTickIn, .rssiIn);
  always #5 sys_clk = ~sys_clk;
  // =====
  // tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic busOp(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    hsel <= 1'b1; hwrite <= wr; htrans <= 2'b10; haddr <= {22'h0, idx, 2'b00};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= {24'h0, wd};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata[7:0];
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] rd;
    busOp(1'b1, idx, d, rd);
  endtask
  task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] rd;
    busOp(1'b0, idx, 8'h00, rd);
    chk($sformatf("reg %h", idx), {24'h0, exp}, {24'h0, rd});
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task automatic toggles(input int b, input int k, output int t);
    logic last;
    t = 0;
    last = padOut[b];
    repeat (k) begin
      @(posedge sys_clk);
      if (padOut[b] !== last) t++;
      last = padOut[b];
    end
  endtask
  // counted in cycles; one slow tick is 3052 cycles
  task automatic waitRx(input logic lvl, input int lim, output int n);
    n = 0;
    while (rxEnable !== lvl && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // =====
  // tests
  initial begin
    int n;
    logic [7:0] rd;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    foreach (rIdx[i]) rdChk(rIdx[i], rVal[i]);
    rdChk(8'h30, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(8'(8'h0b + i), 8'ha0);
      cyc(3);
      chk("drive", 2'b10, padDrive[2*i +: 2]);
      chk("pullup", 1'b1, padPullup[i]);
      rdChk(8'(8'h0b + i), 8'ha0);
    end
    porOn <= 1'b1;
    cyc(6);
    chk("por pads", 2'b01, padOut[1:0]);
    porOn <= 1'b0;
    cyc(6);
    chk("por pads", 2'b10, padOut[1:0]);
    toggles(2, 16, n);
    chk("clock pad", 1'b1, n >= 4);
    porOn <= 1'b1;
    shutOn <= 1'b1;
    cyc(6);
    chk("shutdown pads", 3'b000, padOut);
    chk("pad enable", 3'b111, padOe);
    shutOn <= 1'b0;
    porOn <= 1'b0;
    wr(8'h0b, 8'h03);
    wr(8'h0c, 8'h04);
    for (int m = 0; m < 8; m++) begin
      for (int r = 0; r < 2; r++) begin
        if (r == 0 || m < 4) begin
          rxForce <= r[0];
          wr(8'h08, 8'(m << 5));
          cyc(6);
          chk("ant pads", r ? {~m[0], m[0]} : {2{m > 3 ? m[0] : m[1]}}, padOut[1:0]);
        end
      end
    end
    rxForce <= 1'b1;
    wr(8'h08, 8'h80);
    toggles(0, 900, n);
    chk("ant sweep", 1'b1, n >= 2);
    sigOn <= 1'b1;
    cyc(1100);
    chk("ant pick", 2'b01, padOut[1:0]);
    toggles(0, 900, n);
    chk("ant lock", 0, n);
    sigOn <= 1'b0;
    wr(8'h27, 8'h50);
    wr(8'h0d, 8'h0e);
    wr(8'h08, 8'h20);
    busOp(1'b0, 8'h04, 8'h00, rd);
    sigOn <= 1'b1;
    cyc(1100);
    rdChk(8'h26, 8'h60);
    rdChk(8'h26, 8'h60);
    busOp(1'b0, 8'h04, 8'h00, rd);
    chk("level flag", 1'b1, rd[4]);
    busOp(1'b0, 8'h04, 8'h00, rd);
    chk("level flag", 1'b0, rd[4]);
    chk("level pad", 1'b1, padOut[2]);
    wr(8'h26, 8'hff);
    rdChk(8'h26, 8'h60);
    wr(8'h27, 8'h70);
    cyc(6);
    chk("level pad", 1'b0, padOut[2]);
    sigOn <= 1'b0;
    rxForce <= 1'b0;
    wr(8'h14, 8'h00);
    wr(8'h16, 8'h02);
    wr(8'h19, 8'h01);
    wr(8'h08, 8'h04);
    waitRx(1'b1, 26000, n);
    chk("wake", 1'b1, n < 26000);
    waitRx(1'b0, 13000, n);
    chk("window", 1'b1, n >= 12200 && n <= 12216);
    waitRx(1'b1, 13000, n);
    chk("sleep", 1'b1, n >= 12200 && n <= 12216);
    sigOn <= 1'b1;
    waitRx(1'b0, 16000, n);
    chk("held window", 1'b1, n >= 15252 && n <= 15268);
    sigOn <= 1'b0;
    wr(8'h08, 8'h00);
    waitRx(1'b1, 13000, n);
    chk("disabled", 13000, n);
    print_verdict;
  end
  initial begin
    #950000;
    fails++;
    print_verdict;
  end
endmodule
`default_nettype wire
